// ---- common/prog_pkg.sv ----
/*
  constants, carrier structs and field helpers for the supply-pulse programming front end.
  assumes a 125 MHz aclk and an AXI4-Lite master with 32-bit data.
*/
package prog_pkg;
  // ==========================================================
  // timing
  localparam int          CLK_MHZ  = 125;
  localparam int          KEY_US   = 20;
  localparam int          BURN_US  = 90;
  localparam logic [15:0] KEY_CYC  = 16'(KEY_US * CLK_MHZ);
  localparam logic [15:0] BURN_CYC = 16'(BURN_US * CLK_MHZ);
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  // ==========================================================
  // keys and modes
  localparam logic [1:0] SUF_LAST    = 2'h2;
  localparam logic [3:0] EXT_MIDS    = 4'hB;
  localparam logic [3:0] EXT_SAT     = 4'hF;
  localparam int         READ_FLAG   = 2;
  localparam logic [1:0] REG_BOP_SEL = 2'h0;
  localparam logic [1:0] REG_BOP_POL = 2'h1;
  localparam logic [1:0] REG_OUT_CFG = 2'h2;
  localparam logic [7:0] TRY_START   = 8'h01;
  localparam logic [7:0] HOT_START   = 8'h01;
  // ==========================================================
  // fuse image layout
  localparam int SEL_LSB  = 0;
  localparam int SEL_W    = 8;
  localparam int BPOL_LSB = 8;
  localparam int CFG_LSB  = 9;
  localparam int FALL_W   = 2;
  localparam int POL_BIT  = 2;
  localparam int LOCK_BIT = 4;
  // ==========================================================
  // register map
  localparam logic [31:0] A_CTRL   = 32'h00000000;
  localparam logic [31:0] A_STATUS = 32'h00000004;
  localparam logic [31:0] A_PARAM  = 32'h00000008;
  localparam logic [31:0] A_FUSE   = 32'h0000000C;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          CTRL_LANE = 0;
  localparam int          CTRL_EN = 0;
  localparam int          CTRL_RESTART = 1;
  localparam logic        CTRL_EN_RST = 1'b1;
  localparam int STS_STATE = 0;
  localparam int STS_LOCK  = 3;
  localparam int STS_TRY   = 4;
  localparam int STS_RDBIT = 5;
  localparam int STS_REG   = 6;
  localparam int STS_CODE  = 8;
  localparam int STS_HOT   = 16;
  localparam int STS_SUP   = 24;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_KEY_H = 3'h1, ST_KEY_SUF = 3'h3, ST_TRY = 3'h2,
    ST_BLOW = 3'h6, ST_SPENT = 3'h7, ST_READ = 3'h5, ST_REFUSED = 3'h4
  } st_t;
  typedef struct packed {
    logic sym_valid;
    logic sym_high;
    logic sym_burn;
    logic long_high;
    logic supply_ok;
  } pulse_t;
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;
  // ==========================================================
  // field helpers
  function automatic int fld_lsb(logic [1:0] r);
    case (r)
      REG_BOP_POL: return BPOL_LSB;
      REG_OUT_CFG: return CFG_LSB;
      default:     return SEL_LSB;
    endcase
  endfunction
  function automatic logic [7:0] fld_mask(logic [1:0] r, logic trial);
    case (r)
      REG_BOP_POL: return 8'h01;
      REG_OUT_CFG: return trial ? 8'h07 : 8'h1F;
      default:     return 8'hFF;
    endcase
  endfunction
  function automatic logic [7:0] extract(logic [1:0] r, logic [15:0] img);
    return 8'(img >> fld_lsb(r)) & fld_mask(r, 1'b0);
  endfunction
  function automatic logic [15:0] place(logic [1:0] r, logic [7:0] v);
    return 16'({8'h00, v & fld_mask(r, 1'b0)} << fld_lsb(r));
  endfunction
endpackage

// ---- core/pulse_classifier.sv ----
/*
  level and width classifier for supply-pin programming pulses.
  assumes comparator outputs and supply-good arrive asynchronously to aclk.
*/
`timescale 1ns/1ns
module pulse_classifier #(
  parameter logic [15:0] BURN_CYCLES = prog_pkg::BURN_CYC
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       pulse_mid_level,
  input  wire logic       pulse_high_level,
  input  wire logic       supply_ok,
  output prog_pkg::pulse_t pulse
);
  typedef struct packed {
    logic [1:0]       mid_s;
    logic [1:0]       high_s;
    logic [1:0]       sup_s;
    logic [15:0]      cnt;
    logic             saw_high;
    prog_pkg::pulse_t pulse;
  } cls_t;

  cls_t q;
  cls_t d;
  logic active;

  // ==========================================================
  // classification
  always_comb begin
    d = q;
    d.mid_s = {q.mid_s[0], pulse_mid_level};
    d.high_s = {q.high_s[0], pulse_high_level};
    d.sup_s = {q.sup_s[0], supply_ok};
    d.pulse.sym_valid = 1'b0;
    d.pulse.sym_high = 1'b0;
    d.pulse.sym_burn = 1'b0;
    d.pulse.supply_ok = q.sup_s[1];
    active = q.mid_s[1] | q.high_s[1]; // RQ2
    if (!q.sup_s[1]) begin
      d.cnt = '0;
      d.saw_high = 1'b0;
      d.pulse.long_high = 1'b0;
    end else if (active) begin
      if (q.cnt != prog_pkg::CNT_MAX) d.cnt = q.cnt + 16'h0001;
      if (q.high_s[1]) d.saw_high = 1'b1; // RQ2
      d.pulse.long_high = q.high_s[1] && (q.cnt >= BURN_CYCLES); // RQ10
    end else begin
      // slow edges pass through mid on the way to high; peak level wins
      if (q.cnt >= prog_pkg::KEY_CYC) begin // RQ9 RQ16
        d.pulse.sym_valid = 1'b1; // RQ1
        d.pulse.sym_high = q.saw_high;
        d.pulse.sym_burn = q.saw_high && (q.cnt >= BURN_CYCLES); // RQ10
      end
      d.cnt = '0;
      d.saw_high = 1'b0;
      d.pulse.long_high = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) q <= '0;
    else q <= d;
  end

  assign pulse = q.pulse;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_short_drop: assert property (pulse.sym_valid |-> $past(q.cnt) >= prog_pkg::KEY_CYC) // RQ16
    else $error("symbol from a pulse shorter than the key width");
  a_burn_width: assert property (pulse.sym_burn |-> pulse.sym_high && $past(q.cnt) >= BURN_CYCLES) // RQ10
    else $error("burn symbol from a short or mid pulse");
endmodule // pulse_classifier

// ---- core/prog_front_end.sv ----
/*
  supply-pulse programming front end: key decoder, try/blow/read modes, AXI4-Lite registers.
  assumes analog comparators on the supply pin and a fuse array with sense and burn ports.
*/
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// RQ1: parameters are selected and changed only by pulse trains on the supply pin.
// RQ2: every pulse is classified as low, mid or high level.
// RQ3: trial values apply at once and vanish at supply loss.
// RQ4: blow mode burns the addressed fuse permanently.
// RQ5: the lock bit can only be set through blow mode.
// RQ6: read mode reports whether each addressed fuse is blown.
// RQ7: once locked, every register access is refused; fuse checking remains.
// RQ8: programmer keeps supply low at least 20 us between pulses.
// RQ9: key and code pulses last at least 20 us.
// RQ10: a high pulse of at least 90 us is a burn, not a key symbol.
// RQ11: only a complete well-formed sequence programs anything.
// RQ12: key is high, mid, then a register-specific high/mid pattern.
// RQ13: eleven mids then one high after the key select blow or read mode.
// RQ14: try code starts at 1 and steps by one per mid pulse.
// RQ15: blow addressing is a one-hot shift; one fuse per power-up; a CTRL restart write also returns the spent state to idle.
// RQ16: short excursions are ignored and supply loss abandons a partial key.
// RQ17: programmer starts every session from a fresh power-up.
module prog_front_end #(
  parameter logic [15:0] BURN_CYCLES = prog_pkg::BURN_CYC
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  prog_pkg::axi_req_t axi_req,
  output prog_pkg::axi_rsp_t axi_rsp,
  input  wire logic         pulse_mid_level,
  input  wire logic         pulse_high_level,
  input  wire logic         supply_ok,
  input  wire logic [15:0]  fuse_image,
  output logic [7:0]        bop_sel,
  output logic              bop_pol,
  output logic [1:0]        fall_time,
  output logic              out_pol,
  output logic              locked,
  output logic              fuse_burn_en,
  output logic [15:0]       fuse_burn_sel,
  output logic              readback_bit
);
  typedef struct packed {
    logic [15:0]    fa_s1;
    logic [15:0]    fa_s2;
    prog_pkg::st_t  st;
    logic [1:0]     suf;
    logic [1:0]     suf_cnt;
    logic [1:0]     reg_sel;
    logic           read_key;
    logic [3:0]     ext_cnt;
    logic [7:0]     try_code;
    logic           try_en;
    logic [7:0]     onehot;
    logic           rd_bit;
    logic           burn_en;
    logic [15:0]    burn_sel;
    logic [15:0]    param;
    logic           ctrl_en;
    logic           aw_got;
    logic [31:0]    awaddr;
    logic           w_got;
    logic [31:0]    wdata;
    logic [3:0]     wstrb;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
  } core_t;

  localparam core_t CORE_RST = '{ctrl_en: prog_pkg::CTRL_EN_RST, st: prog_pkg::ST_IDLE,
                                 default: '0};

  core_t            q;
  core_t            d;
  prog_pkg::pulse_t pulse;
  logic             locked_w;
  logic             ev_mid;
  logic             ev_high;
  logic             ev_burn;
  logic             restart;
  logic             rd_w;
  logic [2:0]       key_w;
  logic [7:0]       try_max;
  logic [31:0]      status_w;

  // ==========================================================
  // pulse front end
  pulse_classifier #(
    .BURN_CYCLES (BURN_CYCLES)
  ) u_cls (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .pulse_mid_level  (pulse_mid_level),
    .pulse_high_level (pulse_high_level),
    .supply_ok        (supply_ok),
    .pulse            (pulse)
  );

  assign locked_w = q.fa_s2[prog_pkg::CFG_LSB + prog_pkg::LOCK_BIT];
  assign ev_mid = pulse.sym_valid && q.ctrl_en && !pulse.sym_high;
  assign ev_high = pulse.sym_valid && q.ctrl_en && pulse.sym_high && !pulse.sym_burn;
  assign ev_burn = pulse.sym_valid && q.ctrl_en && pulse.sym_burn;
  assign key_w = {q.suf, pulse.sym_high};
  assign try_max = prog_pkg::fld_mask(q.reg_sel, 1'b1);
  assign rd_w = |(prog_pkg::extract(q.reg_sel, q.fa_s2) & q.onehot); // RQ6

  always_comb begin
    status_w = '0;
    status_w[prog_pkg::STS_STATE +: 3] = q.st;
    status_w[prog_pkg::STS_LOCK] = locked_w;
    status_w[prog_pkg::STS_TRY] = q.try_en;
    status_w[prog_pkg::STS_RDBIT] = q.rd_bit;
    status_w[prog_pkg::STS_REG +: 2] = q.reg_sel;
    status_w[prog_pkg::STS_CODE +: 8] = q.try_code;
    status_w[prog_pkg::STS_HOT +: 8] = q.onehot;
    status_w[prog_pkg::STS_SUP] = pulse.supply_ok;
  end

  // ==========================================================
  // next state
  always_comb begin
    d = q;
    restart = 1'b0;
    d.fa_s1 = fuse_image;
    d.fa_s2 = q.fa_s1;
    // register bus, write side
    if (axi_req.awvalid && axi_rsp.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      d.w_got = 1'b1;
      d.wdata = axi_req.wdata;
      d.wstrb = axi_req.wstrb;
    end
    if (q.bvalid && axi_req.bready) d.bvalid = 1'b0;
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.bvalid = 1'b1;
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bresp = prog_pkg::RESP_OKAY;
      case (q.awaddr)
        prog_pkg::A_CTRL: begin
          if (q.wstrb[prog_pkg::CTRL_LANE]) begin
            d.ctrl_en = q.wdata[prog_pkg::CTRL_EN];
            restart = q.wdata[prog_pkg::CTRL_RESTART];
          end
        end
        prog_pkg::A_STATUS, prog_pkg::A_PARAM, prog_pkg::A_FUSE: d.bresp = prog_pkg::RESP_OKAY;
        default: d.bresp = prog_pkg::RESP_SLVERR;
      endcase
    end
    // register bus, read side
    if (q.rvalid && axi_req.rready) d.rvalid = 1'b0;
    if (axi_req.arvalid && axi_rsp.arready) begin
      d.rvalid = 1'b1;
      d.rresp = prog_pkg::RESP_OKAY;
      case (axi_req.araddr)
        prog_pkg::A_CTRL:   d.rdata = 32'({q.ctrl_en} << prog_pkg::CTRL_EN);
        prog_pkg::A_STATUS: d.rdata = status_w;
        prog_pkg::A_PARAM:  d.rdata = {16'h0000, q.param};
        prog_pkg::A_FUSE:   d.rdata = {16'h0000, q.fa_s2}; // RQ7
        default: begin
          d.rdata = '0;
          d.rresp = prog_pkg::RESP_SLVERR;
        end
      endcase
    end
    // key decoder and modes
    d.burn_en = 1'b0;
    case (q.st)
      prog_pkg::ST_IDLE: begin
        if (ev_high) d.st = prog_pkg::ST_KEY_H; // RQ12
      end
      prog_pkg::ST_KEY_H: begin
        if (ev_mid) begin
          d.st = prog_pkg::ST_KEY_SUF; // RQ12
          d.suf_cnt = '0;
        end else if (ev_high || ev_burn) begin
          d.st = prog_pkg::ST_IDLE; // RQ11
        end
      end
      prog_pkg::ST_KEY_SUF: begin
        if (ev_burn) begin
          d.st = prog_pkg::ST_IDLE; // RQ11
        end else if (ev_mid || ev_high) begin
          d.suf = key_w[1:0];
          d.suf_cnt = q.suf_cnt + 2'h1;
          if (q.suf_cnt == prog_pkg::SUF_LAST) begin
            d.reg_sel = key_w[1:0];
            d.read_key = key_w[prog_pkg::READ_FLAG];
            if (key_w[1:0] > prog_pkg::REG_OUT_CFG) begin
              d.st = prog_pkg::ST_IDLE; // RQ11
            end else if (locked_w) begin
              d.st = prog_pkg::ST_REFUSED; // RQ7
            end else begin
              d.st = prog_pkg::ST_TRY;
              d.try_code = prog_pkg::TRY_START; // RQ14
              d.try_en = 1'b1; // RQ3
              d.ext_cnt = '0;
            end
          end
        end
      end
      prog_pkg::ST_TRY: begin
        if (ev_mid) begin
          d.try_code = (q.try_code >= try_max) ? 8'h00 : q.try_code + 8'h01; // RQ14
          if (q.ext_cnt != prog_pkg::EXT_SAT) d.ext_cnt = q.ext_cnt + 4'h1;
        end else if (ev_high && q.ext_cnt == prog_pkg::EXT_MIDS) begin
          d.st = q.read_key ? prog_pkg::ST_READ : prog_pkg::ST_BLOW; // RQ13
          d.try_en = 1'b0;
          d.onehot = prog_pkg::HOT_START;
        end
      end
      prog_pkg::ST_BLOW: begin
        if (ev_mid) d.onehot = q.onehot << 1; // RQ15
        // only the blow state drives the burn strobe, so lock is burnt here alone
        d.burn_en = pulse.long_high && (q.onehot != 8'h00); // RQ4 RQ5
        d.burn_sel = prog_pkg::place(q.reg_sel, q.onehot); // RQ4
        if (ev_burn) d.st = prog_pkg::ST_SPENT; // RQ15
      end
      prog_pkg::ST_READ: begin
        if (ev_mid) d.onehot = q.onehot << 1; // RQ6
      end
      prog_pkg::ST_SPENT, prog_pkg::ST_REFUSED: d.st = q.st;
      default: d.st = prog_pkg::ST_IDLE;
    endcase
    d.rd_bit = (q.st == prog_pkg::ST_READ) && rd_w; // RQ6
    // supply loss behaves as a power cycle: partial keys and trial values go
    if (!pulse.supply_ok || restart) begin
      d.st = prog_pkg::ST_IDLE; // RQ16
      d.try_en = 1'b0; // RQ3
      d.onehot = '0;
      d.burn_en = 1'b0;
    end
    d.param = q.fa_s2 | (q.try_en ? prog_pkg::place(q.reg_sel, q.try_code & try_max) : 16'h0000); // RQ3
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) q <= CORE_RST;
    else q <= d;
  end

  // ==========================================================
  // outputs
  assign axi_rsp.awready = !q.aw_got && !q.bvalid;
  assign axi_rsp.wready = !q.w_got && !q.bvalid;
  assign axi_rsp.bvalid = q.bvalid;
  assign axi_rsp.bresp = q.bresp;
  assign axi_rsp.arready = !q.rvalid;
  assign axi_rsp.rvalid = q.rvalid;
  assign axi_rsp.rdata = q.rdata;
  assign axi_rsp.rresp = q.rresp;
  assign bop_sel = q.param[prog_pkg::SEL_LSB +: prog_pkg::SEL_W];
  assign bop_pol = q.param[prog_pkg::BPOL_LSB];
  assign fall_time = q.param[prog_pkg::CFG_LSB +: prog_pkg::FALL_W];
  assign out_pol = q.param[prog_pkg::CFG_LSB + prog_pkg::POL_BIT];
  assign locked = locked_w;
  assign fuse_burn_en = q.burn_en;
  assign fuse_burn_sel = q.burn_sel;
  assign readback_bit = q.rd_bit;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_burn_only_blow: assert property (q.burn_en |-> $past(q.st) == prog_pkg::ST_BLOW) // RQ5
    else $error("burn strobe outside blow mode");
  a_burn_one_fuse: assert property (q.burn_en |-> $onehot(q.burn_sel)) // RQ15
    else $error("burn strobe addresses other than one fuse");
  a_try_no_lock: assert property (q.try_en |-> !q.param[prog_pkg::CFG_LSB + prog_pkg::LOCK_BIT]
                                  || q.fa_s2[prog_pkg::CFG_LSB + prog_pkg::LOCK_BIT]) // RQ5
    else $error("trial value reached the lock bit");
  a_lock_refuse: assert property ((q.st == prog_pkg::ST_KEY_SUF) ##1 (q.st == prog_pkg::ST_TRY)
                                  |-> !$past(locked_w)) // RQ7
    else $error("register opened while locked");
  a_try_start: assert property ((q.st == prog_pkg::ST_KEY_SUF) ##1 (q.st == prog_pkg::ST_TRY)
                                |-> q.try_code == prog_pkg::TRY_START) // RQ14
    else $error("trial code did not start at one");
  a_try_step: assert property (q.st == prog_pkg::ST_TRY && ev_mid && pulse.supply_ok && !restart
                               |=> q.try_code != $past(q.try_code)) // RQ14
    else $error("mid pulse did not step the trial code");
  a_mode_entry: assert property ((q.st == prog_pkg::ST_TRY) ##1
                                 (q.st == prog_pkg::ST_BLOW || q.st == prog_pkg::ST_READ)
                                 |-> $past(q.ext_cnt) == prog_pkg::EXT_MIDS) // RQ13
    else $error("blow or read entered without the mode key");
  a_spent_hold: assert property (q.st == prog_pkg::ST_SPENT && pulse.supply_ok && !restart
                                 |=> q.st == prog_pkg::ST_SPENT) // RQ15
    else $error("second blow allowed without a power cycle");
  a_supply_abort: assert property (!pulse.supply_ok |=> q.st == prog_pkg::ST_IDLE && !q.try_en) // RQ16
    else $error("supply loss did not clear the programming state");
  a_idle_noise: assert property (q.st == prog_pkg::ST_IDLE && !ev_high
                                 |=> q.st == prog_pkg::ST_IDLE) // RQ11
    else $error("key decoder left idle without a high pulse");
  c_try: cover property ((q.st == prog_pkg::ST_KEY_SUF) ##1 (q.st == prog_pkg::ST_TRY));
  c_burn: cover property (q.burn_en ##1 !q.burn_en);
  c_read: cover property (q.st == prog_pkg::ST_READ && q.rd_bit);
  c_refused: cover property (q.st == prog_pkg::ST_REFUSED);
endmodule // prog_front_end

// ---- test/prog_model.sv ----
/*
  programmer and fuse array model at the far side of the supply pin.
  assumes a 125 MHz aclk; the bench calls send and power_cycle.
*/
`timescale 1ns/1ns
module prog_model (
  input  wire logic        aclk,
  input  wire logic        fuse_burn_en,
  input  wire logic [15:0] fuse_burn_sel,
  output logic             pulse_mid_level,
  output logic             pulse_high_level,
  output logic             supply_ok,
  output logic [15:0]      fuse_image
);
  localparam int GAP_CYC = 2500;
  initial begin
    pulse_mid_level  = 1'b0;
    pulse_high_level = 1'b0;
    supply_ok        = 1'b1;
    fuse_image       = 16'h0000;
  end
  // ==========================================================
  // fuses: a burn is permanent, supply loss never clears it
  always @(posedge aclk) begin
    if (fuse_burn_en) begin
      fuse_image <= fuse_image | fuse_burn_sel;
    end
  end
  // ==========================================================
  // pulses: high drives both comparators, mid only the lower
  task automatic send(input logic high, input int width);
    @(posedge aclk);
    pulse_mid_level  <= 1'b1;
    pulse_high_level <= high;
    repeat (width) @(posedge aclk);
    pulse_mid_level  <= 1'b0;
    pulse_high_level <= 1'b0;
    repeat (GAP_CYC) @(posedge aclk);
  endtask
  task automatic power_cycle();
    @(posedge aclk);
    supply_ok <= 1'b0;
    repeat (20) @(posedge aclk);
    supply_ok <= 1'b1;
    repeat (20) @(posedge aclk);
  endtask
endmodule // prog_model

// ---- test/testbench.sv ----
/*
  self-checking bench: trial key, blow-mode burn, power cycle, lock.
  assumes prog_model on the supply pin and a 125 MHz aclk.
*/
`timescale 1ns/1ns
module testbench;
  localparam logic [15:0] BURN  = 16'h0A8C;
  localparam int          KEY_W = 2520;
  logic                   aclk;
  logic                   aresetn;
  prog_pkg::axi_req_t     axi_req;
  prog_pkg::axi_rsp_t     axi_rsp;
  logic                   pulse_mid_level;
  logic                   pulse_high_level;
  logic                   supply_ok;
  logic [15:0]            fuse_image;
  logic [7:0]             bop_sel;
  logic                   bop_pol;
  logic [1:0]             fall_time;
  logic                   out_pol;
  logic                   locked;
  logic                   fuse_burn_en;
  logic [15:0]            fuse_burn_sel;
  logic                   readback_bit;
  logic [31:0]            rd;
  logic [1:0]             resp;
  int                     fail_count = 0;
  int                     compares = 0;
  int                     cyc = 0;

  prog_front_end #(.BURN_CYCLES(BURN)) u_prog_front_end (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .pulse_mid_level(pulse_mid_level), .pulse_high_level(pulse_high_level),
    .supply_ok(supply_ok), .fuse_image(fuse_image), .bop_sel(bop_sel),
    .bop_pol(bop_pol), .fall_time(fall_time), .out_pol(out_pol), .locked(locked),
    .fuse_burn_en(fuse_burn_en), .fuse_burn_sel(fuse_burn_sel),
    .readback_bit(readback_bit));
  prog_model u_prog_model (
    .aclk(aclk), .fuse_burn_en(fuse_burn_en), .fuse_burn_sel(fuse_burn_sel),
    .pulse_mid_level(pulse_mid_level), .pulse_high_level(pulse_high_level),
    .supply_ok(supply_ok), .fuse_image(fuse_image));

  // ==========================================================
  // clock, timeout and verdict
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // ceiling sits just above the ~93.4k cycles the pulse trains take
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // ==========================================================
  // bus master: handshakes judged just before the taking edge
  task automatic axi(input logic wr, input logic [31:0] a, input logic [31:0] d);
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic done;
    int   n;
    done = 1'b0;
    n = 0;
    @(posedge aclk);
    axi_req.awvalid <= wr;
    axi_req.wvalid  <= wr;
    axi_req.bready  <= wr;
    axi_req.awaddr  <= a;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hF;
    axi_req.arvalid <= !wr;
    axi_req.araddr  <= a;
    axi_req.rready  <= !wr;
    // no wait limit here: only the bench timeout ends a hung transfer
    while (!done) begin
      @(negedge aclk);
      n++;
      aw_hs = axi_req.awvalid && axi_rsp.awready;
      w_hs  = axi_req.wvalid && axi_rsp.wready;
      ar_hs = axi_req.arvalid && axi_rsp.arready;
      done  = (axi_req.bready && axi_rsp.bvalid) || (axi_req.rready && axi_rsp.rvalid);
      rd    = axi_rsp.rdata;
      resp  = wr ? axi_rsp.bresp : axi_rsp.rresp;
      @(posedge aclk);
      if (aw_hs) axi_req.awvalid <= 1'b0;
      if (w_hs) axi_req.wvalid <= 1'b0;
      if (ar_hs) axi_req.arvalid <= 1'b0;
      if (done) axi_req.bready <= 1'b0;
      if (done) axi_req.rready <= 1'b0;
    end
    chk("bus latency", wr ? 32'h3 : 32'h2, 32'(n));
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    axi(1'b0, prog_pkg::A_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    axi(1'b0, 32'h00000040, 32'h0);
    chk("unmapped resp", 32'(prog_pkg::RESP_SLVERR), 32'(resp));
    axi(1'b1, 32'h00000040, 32'h0);
    chk("unmapped write resp", 32'(prog_pkg::RESP_SLVERR), 32'(resp));
    axi(1'b1, prog_pkg::A_STATUS, 32'hFFFFFFFF);
    chk("ro write resp", 32'(prog_pkg::RESP_OKAY), 32'(resp));
  endtask
  task automatic t_key();
    u_prog_model.send(1'b1, 100);
    axi(1'b0, prog_pkg::A_STATUS, 32'h0);
    chk("glitch state", 32'h0, 32'(rd[2:0]));
    u_prog_model.send(1'b1, KEY_W);
    u_prog_model.send(1'b0, KEY_W);
    u_prog_model.send(1'b0, KEY_W);
    u_prog_model.send(1'b0, KEY_W);
    u_prog_model.send(1'b1, KEY_W);
    axi(1'b0, prog_pkg::A_STATUS, 32'h0);
    chk("try state", 32'(prog_pkg::ST_TRY), 32'(rd[2:0]));
    chk("try reg", 32'(prog_pkg::REG_BOP_POL), 32'(rd[7:6]));
    chk("try code", 32'h1, 32'(rd[15:8]));
    chk("try bop_pol", 32'h1, 32'(bop_pol));
  endtask
  task automatic t_mode();
    repeat (11) u_prog_model.send(1'b0, KEY_W);
    chk("wrapped bop_pol", 32'h0, 32'(bop_pol));
    u_prog_model.send(1'b1, KEY_W);
    axi(1'b0, prog_pkg::A_STATUS, 32'h0);
    chk("blow state", 32'(prog_pkg::ST_BLOW), 32'(rd[2:0]));
    chk("blow onehot", 32'h1, 32'(rd[23:16]));
    chk("trial cleared", 32'h0, 32'(rd[4]));
  endtask
  task automatic t_burn();
    u_prog_model.send(1'b1, 32'(BURN) + 200);
    chk("burned fuses", 32'h0100, 32'(fuse_image));
    chk("burn strobe ended", 32'h0, 32'(fuse_burn_en));
    chk("readback outside read", 32'h0, 32'(readback_bit));
    axi(1'b0, prog_pkg::A_STATUS, 32'h0);
    chk("spent state", 32'(prog_pkg::ST_SPENT), 32'(rd[2:0]));
  endtask
  task automatic t_power();
    u_prog_model.power_cycle();
    axi(1'b0, prog_pkg::A_STATUS, 32'h0);
    chk("idle after cycle", 32'(prog_pkg::ST_IDLE), 32'(rd[2:0]));
    chk("fused bop_pol", 32'h1, 32'(bop_pol));
    chk("fused bop_sel", 32'h0, 32'(bop_sel));
    chk("fused fall_time", 32'h0, 32'(fall_time));
    chk("fused out_pol", 32'h0, 32'(out_pol));
    axi(1'b0, prog_pkg::A_PARAM, 32'h0);
    chk("param image", 32'h0100, rd);
    axi(1'b1, prog_pkg::A_CTRL, 32'h3);
    axi(1'b0, prog_pkg::A_CTRL, 32'h0);
    chk("restart self clears", 32'h1, rd);
  endtask
  task automatic t_lock();
    u_prog_model.fuse_image <= 16'h2100;
    repeat (8) @(posedge aclk);
    chk("locked", 32'h1, 32'(locked));
    axi(1'b0, prog_pkg::A_STATUS, 32'h0);
    chk("status lock", 32'h1, 32'(rd[3]));
    axi(1'b0, prog_pkg::A_FUSE, 32'h0);
    chk("fuse check when locked", 32'h2100, rd);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    axi_req = '0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_regs();
    t_key();
    t_mode();
    t_burn();
    t_power();
    t_lock();
    test_done();
  end
endmodule // testbench
